// ---- qcm_top.sv ----
// Top: QoS classifier and token-bucket meter with three-colour marking
//
// Summary of operation
// - DS byte: 6-bit code point, 2 unused
// - Precedence is top three bits, 0..7
// - Unmatched packets get automatic queue when enabled
// - Higher queue index means higher service
// - Precedence 1..7 mapped to queues 3..7; 0 to queue 2, or 0 with zeroToQ0
// - Listed nonzero code points mapped to queues 3..7; others to queue 2, or 0 with zeroToQ0
// - Length selects queue 2, 3 or 5
// - Tokens are bytes, capped at bucket size
// - Tokens added at constant configured rate
// - Conform if tokens cover length; debit it
// - Empty bucket stalls the metered flow when shaping
// - Shaping holds non-conforming packet
// - Policing drops or re-marks non-conforming packet
// - Colour encodes loss priority
// - Committed overflow fills excess bucket
// - Single-rate: green, yellow, red by buckets
// - Dropped packets leave buckets unchanged
// - Two-rate: committed and peak buckets
// - Two-rate: peak shortfall means red
// - Two-rate: committed decides green or yellow
`timescale 1ns/1ns
`default_nettype none
module qcm_top
    import qcm_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire qcm_cfg_t cfg,
    input wire logic inValid,
    output logic inReady,
    input wire qcm_desc_t inDesc,
    output logic outValid,
    input wire logic outReady,
    output qcm_verdict_t outVerdict,
    output logic [QCM_TOK_W-1:0] commitTokens,
    output logic [QCM_TOK_W-1:0] excessTokens
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [QCM_TOK_W-1:0] cTok;
        logic [QCM_TOK_W-1:0] eTok;
        logic outValid;
        qcm_verdict_t verdict;
    } qcm_state_t;

    qcm_state_t st;
    qcm_state_t next_st;
    logic [2:0] classQueue;
    logic [QCM_TOK_W-1:0] len;

    qcm_classify qcm_classify_i (
        .desc(inDesc),
        .enable(cfg.enable),
        .sel(cfg.sel),
        .zeroToQ0(cfg.zeroToQ0),
        .queue(classQueue)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [QCM_TOK_W-1:0] sat_add(
        input logic [QCM_TOK_W-1:0] tok,
        input logic [QCM_TOK_W-1:0] add,
        input logic [QCM_TOK_W-1:0] cap
    );
        logic [QCM_TOK_W:0] sum;
        sum = {1'b0, tok} + {1'b0, add};
        if (sum > {1'b0, cap}) begin
            return cap;
        end
        return sum[QCM_TOK_W-1:0];
    endfunction

    function automatic logic [QCM_TOK_W-1:0] overflow(
        input logic [QCM_TOK_W-1:0] tok,
        input logic [QCM_TOK_W-1:0] add,
        input logic [QCM_TOK_W-1:0] cap
    );
        logic [QCM_TOK_W:0] sum;
        sum = {1'b0, tok} + {1'b0, add};
        if (sum > {1'b0, cap}) begin
            return QCM_TOK_W'(sum - {1'b0, cap});
        end
        return QCM_TOK_RESET;
    endfunction

    // ****************************************************************
    // Metering
    // ****************************************************************
    logic takeIn;
    logic cOk;
    logic eOk;
    logic conform;
    logic holdPkt;
    qcm_color_t color;
    logic [QCM_TOK_W-1:0] cRate;
    logic [QCM_TOK_W-1:0] pRate;

    assign len = QCM_TOK_W'(inDesc.length);
    assign cRate = QCM_TOK_W'(cfg.cir);
    assign pRate = QCM_TOK_W'(cfg.pir);

    always_comb begin
        next_st = st;
        cOk = st.cTok >= len;
        eOk = st.eTok >= len;
        color = QCM_RED;
        unique case (cfg.mode)
            QCM_MODE_SRTCM: begin
                if (cOk) begin
                    color = QCM_GREEN;
                end else if (eOk) begin
                    color = QCM_YELLOW;
                end
            end
            QCM_MODE_TRTCM: begin
                if (!eOk) begin
                    color = QCM_RED;
                end else if (cOk) begin
                    color = QCM_GREEN;
                end else begin
                    color = QCM_YELLOW;
                end
            end
            default: begin
                if (cOk) begin
                    color = QCM_GREEN;
                end
            end
        endcase
        conform = color != QCM_RED;
        // Shaping stalls the flow until tokens suffice
        holdPkt = cfg.shaping && !conform;
        inReady = (!st.outValid || outReady) && !holdPkt;
        takeIn = inValid && inReady;

        // Token refill; rate is whole tokens per clock
        if (cfg.mode == QCM_MODE_TRTCM) begin
            next_st.cTok = sat_add(st.cTok, cRate, cfg.cbs);
            next_st.eTok = sat_add(st.eTok, pRate, cfg.ebs);
        end else begin
            next_st.cTok = sat_add(st.cTok, cRate, cfg.cbs);
            if (cfg.mode == QCM_MODE_SRTCM) begin
                next_st.eTok = sat_add(st.eTok, overflow(st.cTok, cRate, cfg.cbs),
                    cfg.ebs);
            end
        end

        if (st.outValid && outReady) begin
            next_st.outValid = 1'b0;
        end

        if (takeIn) begin
            next_st.outValid = 1'b1;
            next_st.verdict.queue = classQueue;
            next_st.verdict.color = color;
            next_st.verdict.length = inDesc.length;
            next_st.verdict.tosByte = inDesc.tosByte;
            next_st.verdict.pass = conform;
            next_st.verdict.drop = 1'b0;
            next_st.verdict.remark = 1'b0;
            if (!conform && !cfg.shaping) begin
                if (cfg.policeDrop) begin
                    next_st.verdict.drop = 1'b1;
                end else begin
                    next_st.verdict.remark = 1'b1;
                    next_st.verdict.tosByte = {cfg.remarkDscp, inDesc.tosByte[1:0]};
                end
            end
            // Debit on admission; a dropped packet debits nothing
            if (color == QCM_GREEN) begin
                next_st.cTok = next_st.cTok - len;
                if (cfg.mode == QCM_MODE_TRTCM) begin
                    next_st.eTok = next_st.eTok - len;
                end
            end else if (color == QCM_YELLOW) begin
                next_st.eTok = next_st.eTok - len;
            end
            // Red leaves all buckets untouched
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign outValid = st.outValid;
    assign outVerdict = st.verdict;
    assign commitTokens = st.cTok;
    assign excessTokens = st.eTok;

endmodule
`default_nettype wire

// ---- qcm_pkg.sv ----
// Package: shared constants and types for the QoS classifier and meter
`default_nettype none
package qcm_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int QCM_LEN_W = 16;
    localparam int QCM_TOK_W = 24;
    localparam int QCM_RATE_W = 16;

    // ****************************************************************
    // Classifier constants
    // ****************************************************************
    localparam logic [15:0] QCM_LEN_LONG = 16'h044c;
    localparam logic [15:0] QCM_LEN_SHORT = 16'h00fa;
    localparam logic [2:0] QCM_Q_DEFAULT = 3'h2;
    localparam logic [2:0] QCM_Q_ALT = 3'h0;
    localparam int QCM_DSCP_LSB = 2;
    localparam int QCM_PREC_LSB = 5;

    // ****************************************************************
    // Reset values and timing
    // ****************************************************************
    localparam logic [QCM_TOK_W-1:0] QCM_TOK_RESET = 24'h000000;
    localparam logic [QCM_RATE_W-1:0] QCM_TICK_RESET = 16'h0000;
    localparam logic [5:0] QCM_DSCP_REMARK_RESET = 6'h00;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        QCM_SEL_USERPRI,
        QCM_SEL_PREC,
        QCM_SEL_DSCP,
        QCM_SEL_LENGTH
    } qcm_sel_t;

    typedef enum logic [1:0] {
        QCM_MODE_SINGLE,
        QCM_MODE_SRTCM,
        QCM_MODE_TRTCM
    } qcm_mode_t;

    // Loss priority: green low, yellow medium, red high
    typedef enum logic [1:0] {
        QCM_GREEN = 2'h0,
        QCM_YELLOW = 2'h1,
        QCM_RED = 2'h2
    } qcm_color_t;

    typedef struct packed {
        logic [2:0] userPri;
        logic [7:0] tosByte;
        logic [QCM_LEN_W-1:0] length;
        logic matched;
        logic [2:0] matchedQueue;
    } qcm_desc_t;

    typedef struct packed {
        logic [2:0] queue;
        qcm_color_t color;
        logic pass;
        logic drop;
        logic remark;
        logic [7:0] tosByte;
        logic [QCM_LEN_W-1:0] length;
    } qcm_verdict_t;

    typedef struct packed {
        logic enable;
        qcm_sel_t sel;
        logic zeroToQ0;
        qcm_mode_t mode;
        logic shaping;
        logic policeDrop;
        logic [5:0] remarkDscp;
        logic [QCM_RATE_W-1:0] cir;
        logic [QCM_RATE_W-1:0] pir;
        logic [QCM_TOK_W-1:0] cbs;
        logic [QCM_TOK_W-1:0] ebs;
    } qcm_cfg_t;

endpackage
`default_nettype wire

// ---- qcm_classify.sv ----
// Classifier: picks a priority queue for a packet descriptor
`timescale 1ns/1ns
`default_nettype none
module qcm_classify
    import qcm_pkg::*;
(
    input wire qcm_desc_t desc,
    input wire logic enable,
    input wire qcm_sel_t sel,
    input wire logic zeroToQ0,
    output logic [2:0] queue
);

    // ****************************************************************
    // Mapping functions
    // ****************************************************************
    function automatic logic [2:0] zero_queue(input logic toQ0);
        return toQ0 ? QCM_Q_ALT : QCM_Q_DEFAULT;
    endfunction

    function automatic logic [2:0] prec_queue(input logic [2:0] p, input logic toQ0);
        unique case (p)
            3'h0: prec_queue = zero_queue(toQ0);
            3'h1: prec_queue = 3'h3;
            3'h2: prec_queue = 3'h4;
            3'h3: prec_queue = 3'h5;
            3'h4, 3'h5: prec_queue = 3'h6;
            default: prec_queue = 3'h7;
        endcase
    endfunction

    function automatic logic [2:0] dscp_queue(input logic [5:0] d, input logic toQ0);
        logic [2:0] q;
        q = zero_queue(toQ0);
        if (d == 6'h00) begin
            q = zero_queue(toQ0);
        end else if (d[0] == 1'b0 && d[5:3] >= 3'h1 && d[5:3] <= 3'h3) begin
            q = d[5:3] + 3'h2;
        end else if (d[5:3] == 3'h4 && d[0] == 1'b0) begin
            q = 3'h6;
        end else if (d == 6'h28 || d == 6'h2e) begin
            q = 3'h6;
        end else if (d == 6'h30 || d == 6'h38) begin
            q = 3'h7;
        end
        return q;
    endfunction

    // ****************************************************************
    // Queue selection
    // ****************************************************************
    always_comb begin
        queue = zero_queue(zeroToQ0);
        if (desc.matched || !enable) begin
            queue = desc.matchedQueue;
        end else begin
            unique case (sel)
                QCM_SEL_USERPRI: begin
                    unique case (desc.userPri)
                        3'h0: queue = 3'h2;
                        3'h1: queue = 3'h0;
                        3'h2: queue = 3'h1;
                        default: queue = desc.userPri;
                    endcase
                end
                QCM_SEL_PREC: queue = prec_queue(desc.tosByte[7:QCM_PREC_LSB], zeroToQ0);
                QCM_SEL_DSCP: queue = dscp_queue(desc.tosByte[7:QCM_DSCP_LSB], zeroToQ0);
                QCM_SEL_LENGTH: begin
                    if (desc.length > QCM_LEN_LONG) begin
                        queue = 3'h2;
                    end else if (desc.length >= QCM_LEN_SHORT) begin
                        queue = 3'h3;
                    end else begin
                        queue = 3'h5;
                    end
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ---- qcm_top_asserts.sv ----
// Checker: port assertions of the QoS classifier and meter
`timescale 1ns/1ns
`default_nettype none
module qcm_top_asserts
    import qcm_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire qcm_cfg_t cfg,
    input wire logic inValid,
    input wire logic inReady,
    input wire qcm_desc_t inDesc,
    input wire logic outValid,
    input wire logic outReady,
    input wire qcm_verdict_t outVerdict,
    input wire logic [QCM_TOK_W-1:0] commitTokens,
    input wire logic [QCM_TOK_W-1:0] excessTokens
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_answer_next: assert property (inValid && inReady |=> outValid)
        else $error("no verdict after take");
    a_verdict_stands: assert property (
        outValid && !outReady |=> outValid && $stable(outVerdict))
        else $error("verdict lost while stalled");
    a_commit_cap: assert property (commitTokens <= cfg.cbs)
        else $error("committed bucket over size");
    a_excess_cap: assert property (
        cfg.mode != QCM_MODE_SINGLE |-> excessTokens <= cfg.ebs)
        else $error("second bucket over size");
    a_commit_refill: assert property (
        !(inValid && inReady) && commitTokens + cfg.cir <= cfg.cbs
        |=> commitTokens == $past(commitTokens) + $past(cfg.cir))
        else $error("refill wrong");
    a_red_dropped: assert property (
        outValid && outVerdict.color == QCM_RED && !cfg.shaping && cfg.policeDrop
        |-> outVerdict.drop && !outVerdict.pass)
        else $error("red not dropped");
    a_green_clean: assert property (
        outValid && outVerdict.color == QCM_GREEN
        |-> outVerdict.pass && !outVerdict.drop && !outVerdict.remark)
        else $error("green not passed");
    a_shape_no_red: assert property (
        cfg.shaping && outValid |-> outVerdict.color != QCM_RED)
        else $error("red verdict while shaping");
    a_red_no_debit: assert property (
        inValid && inReady && cfg.cir == 16'h0000 && cfg.pir == 16'h0000
        ##1 outVerdict.color == QCM_RED |-> $stable(commitTokens) && $stable(excessTokens))
        else $error("red packet debited");
endmodule
bind qcm_top qcm_top_asserts qcm_top_asserts_i (.clk(clk), .rstn(rstn), .cfg(cfg),
    .inValid(inValid), .inReady(inReady), .inDesc(inDesc), .outValid(outValid),
    .outReady(outReady), .outVerdict(outVerdict), .commitTokens(commitTokens),
    .excessTokens(excessTokens));
`default_nettype wire

// ---- qcm_sink.sv ----
// Partner model: forwarding datapath sink that takes verdicts
`timescale 1ns/1ns
`default_nettype none
module qcm_sink (
    input wire logic clk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic outValid,
    output logic outReady
);
    logic phase;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase <= 1'h0;
        end else begin
            phase <= outValid ? ~phase : 1'h0;
        end
    end
    // Slow mode stalls the first cycle of each verdict
    assign outReady = !slow || phase;
endmodule
`default_nettype wire

// ---- qcm_top_test.sv ----
// Testbench: self-checking scenarios for the QoS classifier and meter
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin samplesChecked++; if ((got) !== (exp)) begin errorCnt++; \
    $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module qcm_top_test
    import qcm_pkg::*;
;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic inValid = 1'h0;
    logic slow = 1'h0;
    qcm_cfg_t cfg = '0;
    qcm_desc_t inDesc = '0;
    logic inReady, outValid, outReady;
    qcm_verdict_t outVerdict;
    logic [QCM_TOK_W-1:0] commitTokens, excessTokens;
    int errorCnt = 0;
    int samplesChecked = 0;
    always #20 clk = ~clk;
    qcm_top qcm_top_i (.clk(clk), .rstn(rstn), .cfg(cfg), .inValid(inValid), .inReady(inReady),
        .inDesc(inDesc), .outValid(outValid), .outReady(outReady), .outVerdict(outVerdict),
        .commitTokens(commitTokens), .excessTokens(excessTokens));
    qcm_sink qcm_sink_i (.clk(clk), .rstn(rstn), .slow(slow), .outValid(outValid),
        .outReady(outReady));
    function automatic qcm_desc_t pkt(input logic [2:0] up, input logic [7:0] tos,
        input logic [15:0] len);
        return '{up, tos, len, 1'h0, 3'h0};
    endfunction
    task automatic send(input qcm_desc_t d, output qcm_verdict_t v);
        int n;
        n = 0;
        inDesc = d;
        inValid = 1'h1;
        while (inReady !== 1'h1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        #1;
        inValid = 1'h0;
        `CHK("answer", 1'h1, outValid)
        v = outVerdict;
        while (outValid !== 1'h0 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("drain", 1'h0, outValid)
    endtask
    task automatic t_classify();
        qcm_verdict_t v;
        logic [23:0] upQ = 24'hfac642;
        logic [23:0] prQ = 24'hff6b1a;
        logic [5:0] cp [9] = '{6'h08, 6'h0e, 6'h12, 6'h1e, 6'h20, 6'h2e, 6'h30, 6'h38, 6'h00};
        logic [2:0] cq [9] = '{3'h3, 3'h3, 3'h4, 3'h5, 3'h6, 3'h6, 3'h7, 3'h7, 3'h2};
        logic [15:0] ln [4] = '{16'h044d, 16'h044c, 16'h00fa, 16'h00f9};
        logic [2:0] lq [4] = '{3'h2, 3'h3, 3'h3, 3'h5};
        cfg.enable = 1'h1;
        for (int i = 0; i < 9; i++) begin
            cfg.sel = QCM_SEL_DSCP;
            send(pkt(3'h0, {cp[i], 2'h3}, 16'h0040), v);
            `CHK("dscp queue", cq[i], v.queue)
            if (i < 8) begin
                cfg.sel = QCM_SEL_USERPRI;
                send(pkt(i[2:0], 8'h00, 16'h0040), v);
                `CHK("pri queue", upQ[3*i +: 3], v.queue)
                cfg.sel = QCM_SEL_PREC;
                send(pkt(3'h0, {i[2:0], 5'h1f}, 16'h0040), v);
                `CHK("prec queue", prQ[3*i +: 3], v.queue)
            end
            if (i < 4) begin
                cfg.sel = QCM_SEL_LENGTH;
                send(pkt(3'h0, 8'h00, ln[i]), v);
                `CHK("len queue", lq[i], v.queue)
            end
        end
        cfg.sel = QCM_SEL_PREC;
        cfg.zeroToQ0 = 1'h1;
        send(pkt(3'h0, 8'h1f, 16'h0040), v);
        `CHK("zero queue", 3'h0, v.queue)
        send(qcm_desc_t'{3'h7, 8'he0, 16'h0040, 1'h1, 3'h1}, v);
        `CHK("matched queue", 3'h1, v.queue)
        cfg.enable = 1'h0;
        send(qcm_desc_t'{3'h7, 8'he0, 16'h0040, 1'h0, 3'h4}, v);
        `CHK("off queue", 3'h4, v.queue)
        cfg.enable = 1'h1;
    endtask
    task automatic fill(input logic [15:0] c, input logic [15:0] p);
        cfg.cir = c;
        cfg.pir = p;
        repeat (20) @(posedge clk);
        #1;
        cfg.cir = 16'h0000;
        cfg.pir = 16'h0000;
    endtask
    task automatic t_srtcm();
        qcm_verdict_t v;
        cfg.mode = QCM_MODE_SRTCM;
        cfg.ebs = 24'h000032;
        cfg.policeDrop = 1'h1;
        slow = 1'h1;
        fill(16'h000a, 16'h000a);
        `CHK("buckets full", 48'h000064000032, {commitTokens, excessTokens})
        send(pkt(3'h0, 8'h00, 16'h003c), v);
        `CHK("green", QCM_GREEN, v.color)
        `CHK("commit debit", 24'h000028, commitTokens)
        send(pkt(3'h0, 8'h00, 16'h003c), v);
        `CHK("red drop", {QCM_RED, 1'h1}, {v.color, v.drop})
        `CHK("red kept", 48'h000028000032, {commitTokens, excessTokens})
        send(pkt(3'h0, 8'h00, 16'h0032), v);
        `CHK("yellow", QCM_YELLOW, v.color)
        `CHK("excess debit", 48'h000028000000, {commitTokens, excessTokens})
    endtask
    task automatic t_trtcm();
        qcm_verdict_t v;
        cfg.mode = QCM_MODE_TRTCM;
        cfg.ebs = 24'h0000c8;
        cfg.policeDrop = 1'h0;
        cfg.remarkDscp = 6'h2e;
        fill(16'h000a, 16'h0014);
        `CHK("peak full", 48'h0000640000c8, {commitTokens, excessTokens})
        send(pkt(3'h0, 8'h00, 16'h0050), v);
        `CHK("green", QCM_GREEN, v.color)
        `CHK("both debit", 48'h000014000078, {commitTokens, excessTokens})
        send(pkt(3'h0, 8'h00, 16'h0050), v);
        `CHK("yellow", QCM_YELLOW, v.color)
        `CHK("peak debit", 48'h000014000028, {commitTokens, excessTokens})
        send(pkt(3'h0, 8'h00, 16'h0032), v);
        `CHK("red", QCM_RED, v.color)
        `CHK("remark", 7'h6e, {v.remark, v.tosByte[7:2]})
        `CHK("red kept", 48'h000014000028, {commitTokens, excessTokens})
    endtask
    task automatic t_shape();
        qcm_verdict_t v;
        cfg.mode = QCM_MODE_SINGLE;
        cfg.shaping = 1'h1;
        inDesc = pkt(3'h0, 8'h00, 16'h0032);
        inValid = 1'h1;
        repeat (4) @(posedge clk);
        #1;
        `CHK("held", 1'h0, inReady)
        cfg.cir = 16'h0001;
        send(pkt(3'h0, 8'h00, 16'h0032), v);
        `CHK("shaped green", QCM_GREEN, v.color)
        `CHK("length", 16'h0032, v.length)
        `CHK("shaped debit", 24'h000003, commitTokens)
    endtask
    task automatic conclude();
        if (errorCnt == 0 && samplesChecked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        cfg.cbs = 24'h000064;
        repeat (10) @(posedge clk);
        #1;
        rstn = 1'h1;
        t_classify();
        t_srtcm();
        t_trtcm();
        t_shape();
        conclude();
    end
    initial begin
        #400000;
        errorCnt++;
        conclude();
    end
endmodule
`default_nettype wire
